// *** rtl/scm_cal_ctrl.sv ***
// calibration test mode controller with apb register access
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_cal_ctrl #(
  parameter int unsigned MUTE_WINDOW_TICKS = `SCM_MUTE_WINDOW_TICKS
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  // apb slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`SCM_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // pin sense
  input  wire logic                   i_test_below_gnd,
  input  wire logic                   i_test_floating,
  input  wire logic                   i_timebase_pin,
  input  wire logic                   i_io_pin,
  input  wire logic                   i_supply_trip_input,
  input  wire logic                   i_feedback,
  // internal state to expose
  input  wire logic                   i_smoke_latch,
  input  wire logic                   i_photo_cmp,
  input  wire logic                   i_mute_req,
  input  wire scm_pkg::scm_pins_s     i_norm_pins,
  // pins
  output logic                        o_emitter_drive,
  output logic                        o_strobe_n,
  output logic                        o_led_n,
  output logic                        o_horn_drive_a,
  output logic                        o_horn_drive_b,
  output logic                        o_amp_route_en,
  output logic                        o_aux_pins_en,
  output logic                        o_gain_sel,
  output logic                        o_route_sel,
  output logic                        o_hyst_sel,
  output logic                        o_cal_mode,
  output logic                        o_mute_active
);

  scm_pkg::scm_mode_e mode_q;
  logic [1:0]         qual_cnt_q;
  logic               tb_q;
  logic               tb_rise;
  logic               cal;
  logic [31:0]        ctrl_q;
  logic               mute_start;
  logic               mute_stop;
  logic               mute_active;
  logic               bist_n;
  logic [6:0]         phase;
  scm_pkg::scm_pins_s pins_q;
  scm_pkg::scm_aux_s  aux_q;
  logic               wr_en;
  logic               setup;
  logic               ctrl_wr;
  logic [31:0]        status_word;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // one decode per register keeps the read mux, the write path and the
  // silence timer requests from drifting apart
  function automatic logic is_ctrl(input logic [`SCM_ADDR_W-1:0] a);
    return a == `SCM_CTRL_OFS;
  endfunction

  function automatic logic is_status(input logic [`SCM_ADDR_W-1:0] a);
    return a == `SCM_STATUS_OFS;
  endfunction

  function automatic logic addr_ok(input logic [`SCM_ADDR_W-1:0] a);
    return is_ctrl(a) || is_status(a);
  endfunction

  // ----------------------------------------------------------------
  // timebase edge: one rising edge per oscillator cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tb_q <= 1'b0;
    end else begin
      tb_q <= i_timebase_pin;
    end
  end

  assign tb_rise = i_timebase_pin && !tb_q;
  assign cal     = (mode_q == scm_pkg::MODE_CAL) || (mode_q == scm_pkg::MODE_EXITING);

  // ----------------------------------------------------------------
  // mode qualifier
  // ----------------------------------------------------------------
  // two rising edges bound one whole cycle, so a glitch shorter than a
  // cycle never flips the pin functions under a running fixture
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q     <= scm_pkg::MODE_NORMAL;
      qual_cnt_q <= 2'h0;
    end else begin
      unique case (mode_q)
        scm_pkg::MODE_NORMAL: begin
          qual_cnt_q <= 2'h0;
          if (i_test_below_gnd && !ctrl_q[`SCM_CTRL_INHIBIT]) begin
            mode_q <= scm_pkg::MODE_ENTERING;
          end
        end
        scm_pkg::MODE_ENTERING: begin
          if (!i_test_below_gnd || ctrl_q[`SCM_CTRL_INHIBIT]) begin
            mode_q <= scm_pkg::MODE_NORMAL;
          end else if (tb_rise) begin
            if (qual_cnt_q == 2'(`SCM_QUAL_EDGES - 1)) begin
              mode_q <= scm_pkg::MODE_CAL;
            end
            qual_cnt_q <= qual_cnt_q + 2'h1;
          end
        end
        scm_pkg::MODE_CAL: begin
          qual_cnt_q <= 2'h0;
          if (i_test_floating) begin
            mode_q <= scm_pkg::MODE_EXITING;
          end
        end
        scm_pkg::MODE_EXITING: begin
          if (!i_test_floating) begin
            mode_q     <= scm_pkg::MODE_CAL;
            qual_cnt_q <= 2'h0;
          end else if (tb_rise) begin
            if (qual_cnt_q == 2'(`SCM_QUAL_EDGES - 1)) begin
              mode_q <= scm_pkg::MODE_NORMAL;
            end
            qual_cnt_q <= qual_cnt_q + 2'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // silence timer and its built-in test
  // ----------------------------------------------------------------
  // software start and the pin request share one path; lost smoke wins
  assign ctrl_wr    = wr_en && is_ctrl(i_paddr);
  assign mute_start = (i_mute_req || (ctrl_wr && i_pwdata[`SCM_CTRL_MUTE_REQ]))
                      && i_smoke_latch;
  assign mute_stop  = !i_smoke_latch || (ctrl_wr && i_pwdata[`SCM_CTRL_MUTE_STOP]);

  scm_silence_timer #(
    .WINDOW_TICKS (MUTE_WINDOW_TICKS),
    .BIST_PERIOD  (`SCM_BIST_PERIOD),
    .BIST_ACTIVE  (`SCM_BIST_ACTIVE)
  ) u_silence_timer (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_tick    (tb_rise),
    .i_cal     (cal),
    .i_start   (mute_start),
    .i_stop    (mute_stop),
    .o_active  (mute_active),
    .o_bist_n  (bist_n),
    .o_phase   (phase)
  );

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pins_q <= '{emitter_drive: 1'b0, strobe_n: 1'b1, led_n: 1'b1,
                  horn_drive_a: 1'b0, horn_drive_b: 1'b0};
    end else if (cal) begin
      pins_q.emitter_drive <= i_timebase_pin;
      pins_q.strobe_n      <= 1'b0;
      pins_q.led_n         <= bist_n;
      pins_q.horn_drive_a  <= i_smoke_latch;
      pins_q.horn_drive_b  <= i_photo_cmp;
    end else begin
      pins_q <= i_norm_pins;
    end
  end

  // the auxiliary controls only mean anything on the bench; in normal use
  // they sit low so the analog front end keeps its standby settings
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aux_q <= '0;
    end else if (cal && i_io_pin) begin
      aux_q.amp_route_en <= 1'b1;
      aux_q.aux_pins_en  <= 1'b1;
      aux_q.gain_sel     <= i_supply_trip_input;
      aux_q.route_sel    <= i_supply_trip_input;
      aux_q.hyst_sel     <= i_feedback;
    end else begin
      aux_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // mode and timer flags
  // ----------------------------------------------------------------
  // flags lag the internal state by one edge so every pin comes off a flop
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cal_mode    <= 1'b0;
      o_mute_active <= 1'b0;
    end else begin
      o_cal_mode    <= cal;
      o_mute_active <= mute_active;
    end
  end

  assign o_emitter_drive = pins_q.emitter_drive;
  assign o_strobe_n      = pins_q.strobe_n;
  assign o_led_n         = pins_q.led_n;
  assign o_horn_drive_a  = pins_q.horn_drive_a;
  assign o_horn_drive_b  = pins_q.horn_drive_b;
  assign o_amp_route_en  = aux_q.amp_route_en;
  assign o_aux_pins_en   = aux_q.aux_pins_en;
  assign o_gain_sel      = aux_q.gain_sel;
  assign o_route_sel     = aux_q.route_sel;
  assign o_hyst_sel      = aux_q.hyst_sel;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait-free access: ready rises in the access phase from a flop set
  // during setup, so every answer takes exactly two cycles
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !addr_ok(i_paddr);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // status is a snapshot taken at setup, so a field that moves during the
  // access cycle cannot tear the word
  always_comb begin
    status_word                                    = 32'h0000_0000;
    status_word[`SCM_ST_CAL]                       = cal;
    status_word[`SCM_ST_MUTE]                      = mute_active;
    status_word[`SCM_ST_LATCH]                     = i_smoke_latch;
    status_word[`SCM_ST_PHOTO]                     = i_photo_cmp;
    status_word[`SCM_ST_ROUTE]                     = aux_q.amp_route_en;
    status_word[`SCM_ST_MODE_HI:`SCM_ST_MODE_LO]   = mode_q;
    status_word[`SCM_ST_PHASE_HI:`SCM_ST_PHASE_LO] = phase;
  end

  // read data is zero outside the access cycle, so no stale word lingers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite && is_ctrl(i_paddr)) begin
      o_prdata <= {31'h0, ctrl_q[`SCM_CTRL_INHIBIT]};
    end else if (setup && !i_pwrite && is_status(i_paddr)) begin
      o_prdata <= status_word;
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  // request bits are self-clearing; only the inhibit bit is stored
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= `SCM_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= {31'h0, i_pwdata[`SCM_CTRL_INHIBIT]};
    end
  end

endmodule // scm_cal_ctrl

`default_nettype wire

// *** rtl/scm_defines.svh ***
// constants for the calibration test mode block: offsets, fields, resets, timing
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SCM_ADDR_W          12
`define SCM_CTRL_OFS        12'h000
`define SCM_STATUS_OFS      12'h004
`define SCM_CTRL_RST        32'h0000_0000

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SCM_CTRL_INHIBIT    0
`define SCM_CTRL_MUTE_REQ   1
`define SCM_CTRL_MUTE_STOP  2

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SCM_ST_CAL          0
`define SCM_ST_MUTE         1
`define SCM_ST_LATCH        2
`define SCM_ST_PHOTO        3
`define SCM_ST_ROUTE        4
`define SCM_ST_MODE_LO      8
`define SCM_ST_MODE_HI      9
`define SCM_ST_PHASE_LO     16
`define SCM_ST_PHASE_HI     22

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCM_QUAL_EDGES      2
`define SCM_BIST_PERIOD     128
`define SCM_BIST_ACTIVE     8
`define SCM_OSC_PERIOD_US   7900
`define SCM_MUTE_WINDOW_MIN 8
`define SCM_MUTE_WINDOW_TICKS ((`SCM_MUTE_WINDOW_MIN * 60 * 1000000) / `SCM_OSC_PERIOD_US)

`endif

// *** rtl/scm_pkg.sv ***
// types shared by the calibration test mode block
package scm_pkg;

  // ----------------------------------------------------------------
  // operating mode of the test/mute pin qualifier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ENTERING,
    MODE_CAL,
    MODE_EXITING
  } scm_mode_e;

  // ----------------------------------------------------------------
  // pin levels that the normal sequencer would drive
  // ----------------------------------------------------------------
  typedef struct packed {
    logic emitter_drive;
    logic strobe_n;
    logic led_n;
    logic horn_drive_a;
    logic horn_drive_b;
  } scm_pins_s;

  // ----------------------------------------------------------------
  // auxiliary test routing controls
  // ----------------------------------------------------------------
  typedef struct packed {
    logic amp_route_en;
    logic aux_pins_en;
    logic gain_sel;
    logic route_sel;
    logic hyst_sel;
  } scm_aux_s;

endpackage

// *** rtl/scm_silence_timer.sv ***
// silence timer with a free-running built-in test pattern for calibration
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_silence_timer #(
  parameter int unsigned WINDOW_TICKS = `SCM_MUTE_WINDOW_TICKS,
  parameter int unsigned BIST_PERIOD  = `SCM_BIST_PERIOD,
  parameter int unsigned BIST_ACTIVE  = `SCM_BIST_ACTIVE
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_tick,
  input  wire logic        i_cal,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  output logic             o_active,
  output logic             o_bist_n,
  output logic [6:0]       o_phase
);

  localparam int CW = $clog2(WINDOW_TICKS + 1);

  logic [CW-1:0] win_q;
  logic [6:0]    phase_q;

  // ----------------------------------------------------------------
  // mute window, counted in timebase cycles
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_q    <= '0;
      o_active <= 1'b0;
    // a start that meets a stop wins; calibration still ends the window
    end else if (i_cal || (i_stop && !i_start)) begin
      win_q    <= '0;
      o_active <= 1'b0;
    end else if (i_start) begin
      win_q    <= '0;
      o_active <= 1'b1;
    end else if (o_active && i_tick) begin
      if (win_q == CW'(WINDOW_TICKS - 1)) begin
        o_active <= 1'b0;
      end
      win_q <= win_q + CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // calibration pattern: low for the first slots of each period
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_q  <= '0;
      o_bist_n <= 1'b1;
    end else if (!i_cal) begin
      phase_q  <= '0;
      o_bist_n <= 1'b1;
    end else if (i_tick) begin
      phase_q  <= (phase_q == 7'(BIST_PERIOD - 1)) ? 7'h00 : phase_q + 7'h01;
      o_bist_n <= !(phase_q < 7'(BIST_ACTIVE));
    end
  end

  assign o_phase = phase_q;

endmodule // scm_silence_timer

`default_nettype wire

// *** verif/scm_cal_ctrl_assertions.sv ***
// checker for the calibration test mode controller
`timescale 1ns/1ps
`default_nettype none
module scm_cal_ctrl_assertions (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_test_below_gnd,
  input wire logic i_test_floating,
  input wire logic i_timebase_pin,
  input wire logic i_io_pin,
  input wire logic i_supply_trip_input,
  input wire logic i_feedback,
  input wire logic i_smoke_latch,
  input wire logic i_photo_cmp,
  input wire logic o_emitter_drive,
  input wire logic o_strobe_n,
  input wire logic o_led_n,
  input wire logic o_horn_drive_a,
  input wire logic o_horn_drive_b,
  input wire logic o_amp_route_en,
  input wire logic o_aux_pins_en,
  input wire logic o_gain_sel,
  input wire logic o_route_sel,
  input wire logic o_hyst_sel,
  input wire logic o_cal_mode
);
  // ----------
  // helpers: timebase rises counted per held pin level and per led burst
  // ----------
  logic       tb_q;
  logic       cal_q;
  logic [1:0] ent_q;
  logic [1:0] ext_q;
  logic [7:0] lo_q;
  logic       rise;
  logic       both;
  assign rise = i_timebase_pin & ~tb_q;
  assign both = o_cal_mode & cal_q;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tb_q  <= 1'h0;
      cal_q <= 1'h0;
      ent_q <= 2'h0;
      ext_q <= 2'h0;
      lo_q  <= 8'h00;
    end else begin
      tb_q  <= i_timebase_pin;
      cal_q <= o_cal_mode;
      ent_q <= !i_test_below_gnd ? 2'h0 : ent_q + {1'h0, rise && ent_q != 2'h3};
      ext_q <= !i_test_floating ? 2'h0 : ext_q + {1'h0, rise && ext_q != 2'h3};
      lo_q  <= (!o_cal_mode || o_led_n) ? 8'h00 : lo_q + {7'h00, rise};
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_emit; both |-> o_emitter_drive == $past(i_timebase_pin); endproperty
  a_emit: assert property (p_emit) else $error("emitter not following timebase");
  property p_strobe; o_cal_mode |-> !o_strobe_n; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe high in calibration");
  property p_horn; both |-> {o_horn_drive_a, o_horn_drive_b} == $past({i_smoke_latch, i_photo_cmp}); endproperty
  a_horn: assert property (p_horn) else $error("horn drives wrong");
  property p_aux_on; both && $past(i_io_pin) |-> {o_amp_route_en, o_aux_pins_en, o_gain_sel, o_route_sel,
    o_hyst_sel} == {2'h3, $past({i_supply_trip_input, i_supply_trip_input, i_feedback})}; endproperty
  a_aux_on: assert property (p_aux_on) else $error("aux controls wrong");
  property p_aux_off; both && !$past(i_io_pin) |-> !(o_amp_route_en | o_aux_pins_en); endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux pins on with io low");
  property p_led; $rose(o_led_n) && both |-> lo_q == 8'h08; endproperty
  a_led: assert property (p_led) else $error("led burst length wrong");
  property p_entry; $rose(o_cal_mode) |-> ent_q >= 2'h2; endproperty
  a_entry: assert property (p_entry) else $error("entry without full cycle");
  property p_exit; $fell(o_cal_mode) |-> ext_q >= 2'h2; endproperty
  a_exit: assert property (p_exit) else $error("exit without full cycle");
endmodule // scm_cal_ctrl_assertions

bind scm_cal_ctrl scm_cal_ctrl_assertions i_scm_cal_ctrl_assertions (
  .i_ref_clk, .i_sys_rst, .i_test_below_gnd, .i_test_floating, .i_timebase_pin, .i_io_pin,
  .i_supply_trip_input, .i_feedback, .i_smoke_latch, .i_photo_cmp, .o_emitter_drive,
  .o_strobe_n, .o_led_n, .o_horn_drive_a, .o_horn_drive_b, .o_amp_route_en, .o_aux_pins_en,
  .o_gain_sel, .o_route_sel, .o_hyst_sel, .o_cal_mode
);
`default_nettype wire

// *** verif/scm_fixture_model.sv ***
// calibration fixture: test pin levels and a timebase clock it drives
`timescale 1ns/1ps
`default_nettype none
module scm_fixture_model (
  input  wire logic       i_ref_clk,
  input  wire logic [1:0] i_cmd,
  input  wire logic [3:0] i_half,
  output logic            o_below_gnd,
  output logic            o_floating,
  output logic            o_timebase
);
  logic [3:0] cnt_q = 4'h0;
  logic       clk_q = 1'h0;
  // half period in reference cycles; a larger value slows the fixture clock
  always @(posedge i_ref_clk) begin
    if (cnt_q + 4'h1 >= i_half) begin
      cnt_q <= 4'h0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign o_timebase  = clk_q;
  // released test pin sits at its pull-down level: neither sense line set
  assign o_below_gnd = i_cmd == 2'h1;
  assign o_floating  = i_cmd == 2'h2;
endmodule // scm_fixture_model
`default_nettype wire

// *** verif/scm_cal_ctrl_test.sv ***
// self-checking bench for the calibration test mode controller
`timescale 1ns/1ps
`default_nettype none
module scm_cal_ctrl_test;
  logic               clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0, prdata, rnd = 32'h0000_5FF5;
  logic               pready, pslverr, below, flt, tb, tbp = 1'h0, emp = 1'h0, hold = 1'h0;
  logic               smoke = 1'h0, photo = 1'h0, io = 1'h0, trip = 1'h0, fb = 1'h0;
  logic               emit, strobe_n, led_n, ha, hb, amp, auxe, gain, rsel, hyst, cal, mute;
  scm_pkg::scm_pins_s norm = 5'h00, normp = 5'h00;
  logic               mreq = 1'h0, rstp = 1'h1;
  logic [1:0]         cmd = 2'h0;
  logic [3:0]         half = 4'h2;
  logic [64:0]        q[$];
  logic [64:0]        e;
  int                 failures = 0, num_checks = 0, n_low = 0, n_em = 0, a, b;
  scm_cal_ctrl #(.MUTE_WINDOW_TICKS(20)) i_scm_cal_ctrl (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_test_below_gnd(below),
    .i_test_floating(flt), .i_timebase_pin(tb), .i_io_pin(io), .i_supply_trip_input(trip),
    .i_feedback(fb), .i_smoke_latch(smoke), .i_photo_cmp(photo), .i_mute_req(mreq),
    .i_norm_pins(norm), .o_emitter_drive(emit), .o_strobe_n(strobe_n), .o_led_n(led_n),
    .o_horn_drive_a(ha), .o_horn_drive_b(hb), .o_amp_route_en(amp), .o_aux_pins_en(auxe),
    .o_gain_sel(gain), .o_route_sel(rsel), .o_hyst_sel(hyst), .o_cal_mode(cal),
    .o_mute_active(mute));
  scm_fixture_model i_scm_fixture_model (.i_ref_clk(clk), .i_cmd(cmd), .i_half(half),
    .o_below_gnd(below), .o_floating(flt), .o_timebase(tb));
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] s;
    s = v ^ (v << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // expected read data doubles as write data; a zero mask ignores read data
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, m,
                     input logic err);
    int n;
    n = 0;
    q.push_back({d, m, err});
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) chk(1'h0, 1'h1, "apb timeout");
    if (n >= 16) test_done();
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic wait_cal(input logic v);
    int n;
    n = 0;
    while (cal !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(cal, v, "calibration level");
    if (n >= 60) test_done();
  endtask
  // ----------
  // clock, random pin stimulus, answer and pulse monitors
  // ----------
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    rnd <= xs(rnd);
    {smoke, photo, io, trip, fb} <= rnd[4:0] | {hold, 4'h0};
    norm <= rnd[9:5];
    normp <= norm;
    rstp <= rst;
    if (!rst && !rstp && cal === 1'h0)
      chk({emit, strobe_n, led_n, ha, hb}, normp, "normal pins");
    tbp <= tb;
    emp <= emit;
    if (tb && !tbp && led_n === 1'h0) n_low <= n_low + 1;
    if (emit === 1'h1 && emp === 1'h0) n_em <= n_em + 1;
    if (psel && pen && pready === 1'h1) begin
      e = q.pop_front();
      chk({pslverr, prdata & e[32:1]}, {e[0], e[64:33] & e[32:1]}, "apb answer");
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, 12'h000, 32'h0, 32'hFFFF_FFFF, 1'h0);
    apb(1'h0, 12'h008, 32'h0, 32'hFFFF_FFFF, 1'h1);
    apb(1'h1, 12'h000, 32'h1, 32'h0, 1'h0);
    apb(1'h0, 12'h000, 32'h1, 32'hFFFF_FFFF, 1'h0);
    cmd <= 2'h1;
    repeat (40) @(posedge clk);
    chk(cal, 1'h0, "inhibited entry");
    cmd <= 2'h0;
    apb(1'h1, 12'h000, 32'h0, 32'h0, 1'h0);
    cmd <= 2'h1;
    repeat (4) @(posedge clk);
    cmd <= 2'h0;
    repeat (20) @(posedge clk);
    chk(cal, 1'h0, "short hold entered");
    cmd <= 2'h1;
    wait_cal(1'h1);
    cmd <= 2'h0;
    apb(1'h0, 12'h004, 32'h201, 32'h301, 1'h0);
    $display("test entry done");
    // slow fixture first, then back to the fast clock for exit
    for (int h = 5; h >= 2; h -= 3) begin
      half <= h[3:0];
      repeat (20) @(posedge clk);
      a = n_low;
      b = n_em;
      repeat (256 * h) @(posedge clk);
      chk(n_low - a, 8, "led low count");
      chk(n_em - b, 128, "emitter pulse count");
      chk(strobe_n, 1'h0, "strobe level");
    end
    $display("test calibration outputs done");
    cmd <= 2'h2;
    repeat (4) @(posedge clk);
    cmd <= 2'h0;
    repeat (20) @(posedge clk);
    chk(cal, 1'h1, "short float left");
    cmd <= 2'h2;
    wait_cal(1'h0);
    chk({amp, auxe, gain, rsel, hyst}, 5'h00, "aux outside calibration");
    $display("test exit done");
    hold <= 1'h1;
    cmd <= 2'h0;
    apb(1'h1, 12'h000, 32'h2, 32'h0, 1'h0);
    repeat (68) @(posedge clk);
    chk(mute, 1'h1, "silence window early end");
    repeat (40) @(posedge clk);
    chk(mute, 1'h0, "silence window overrun");
    mreq <= 1'h1;
    @(posedge clk);
    mreq <= 1'h0;
    apb(1'h0, 12'h004, 32'h6, 32'h6, 1'h0);
    apb(1'h1, 12'h000, 32'h4, 32'h0, 1'h0);
    repeat (2) @(posedge clk);
    chk(mute, 1'h0, "silence stop ignored");
    hold <= 1'h0;
    $display("test silence timer done");
    cmd <= 2'h1;
    wait_cal(1'h1);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    chk({cal, led_n, strobe_n}, 3'h3, "reset levels");
    rst <= 1'h0;
    cmd <= 2'h2;
    repeat (40) @(posedge clk);
    chk(cal, 1'h0, "floating pin entered");
    $display("test mid-run reset done");
    test_done();
  end
endmodule // scm_cal_ctrl_test
`default_nettype wire
